// ### verilog/ljd_pkg.sv
// Shared constants, opcodes, register map and state codes of the ladder engine
package ljd_pkg;
   // ------------------------------------------------------------
   // Widths and sizes
   // ------------------------------------------------------------
   localparam int PROG_AW = 10;
   localparam int SLOT_AW = 9;
   localparam int INSN_W = 32;
   localparam int SLOT_W = 26;
   localparam int SLOTS = 512;
   localparam int SKIP_SLOTS = 100;
   localparam int IN_W = 16;
   // Instruction layout: opcode on top, slot number, constant at bottom
   localparam int OP_LSB = 25;
   localparam int SLOT_LSB = 16;
   localparam int CONST_W = 16;
   localparam int SKIP_W = 7;
   localparam logic [6:0] OP_IDLE = 7'h00;
   localparam logic [6:0] OP_END = 7'h01;
   localparam logic [6:0] OP_LD = 7'h02;
   localparam logic [6:0] OP_LD_SLOT = 7'h03;
   localparam logic [6:0] OP_SKIP = 7'h04;
   localparam logic [6:0] OP_DEST = 7'h05;
   localparam logic [6:0] OP_OUT = 7'h06;
   localparam logic [6:0] OP_RISE = 7'h0D;
   localparam logic [6:0] OP_FALL = 7'h0E;
   localparam logic [6:0] OP_DELAY = 7'h10;
   localparam logic [6:0] OP_DELAY_IN = 7'h11;
   localparam logic [6:0] OP_CMP = 7'h14;
   localparam logic [INSN_W-1:0] IDLE_WORD = 32'h0000_0000;
   localparam logic [6:0] SKIP_SHARED = 7'h00;
   localparam logic [6:0] SKIP_MAX = 7'h63;
   // Slot word: completion, running, tick stamp, current value
   localparam int SW_DONE = 25;
   localparam int SW_RUN = 24;
   localparam int SW_STAMP_LSB = 16;
   // Condition flags
   localparam int FLAGS_W = 5;
   localparam int FLG_IERR = 0;
   localparam int FLG_CARRY = 1;
   localparam int FLG_GT = 2;
   localparam int FLG_EQU = 3;
   localparam int FLG_LT = 4;
   // Operating modes
   localparam logic [1:0] MODE_PROG = 2'h0;
   localparam logic [1:0] MODE_MON = 2'h1;
   localparam logic [1:0] MODE_RUN = 2'h2;
   // ------------------------------------------------------------
   // Register byte addresses and fields
   // ------------------------------------------------------------
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_STATUS = 6'h04;
   localparam logic [5:0] REG_FLAGS = 6'h08;
   localparam logic [5:0] REG_PADDR = 6'h0C;
   localparam logic [5:0] REG_PDATA = 6'h10;
   localparam logic [5:0] REG_SADDR = 6'h14;
   localparam logic [5:0] REG_SDATA = 6'h18;
   localparam logic [5:0] REG_BITS = 6'h1C;
   localparam logic [5:0] REG_SCANS = 6'h20;
   localparam logic [5:0] REG_INPUT = 6'h24;
   localparam int CTRL_CLEAR_BIT = 2;
   localparam int ST_RUN_BIT = 0;
   localparam int ST_CLR_BIT = 1;
   localparam int ST_PC_LSB = 16;
   localparam int SD_DONE_BIT = 31;
   localparam logic [1:0] MODE_RST = MODE_PROG;
   localparam logic [1:0] BUS_LAST_WAIT = 2'h2;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int TENTH_NS = 100_000_000;
   localparam int TENTH_CYCLES = TENTH_NS / CLK_PERIOD_NS;
   // Engine sequencer states
   typedef enum logic [2:0] {
      S_INIT = 3'h0,
      S_IDLE = 3'h1,
      S_CLEAR = 3'h2,
      S_FETCH = 3'h3,
      S_EXEC = 3'h4,
      S_SLOT = 3'h5,
      S_SRCH_F = 3'h6,
      S_SRCH_C = 3'h7
   } ljd_st_e;
endpackage

// ### verilog/ljd_mem.sv
// Small memory with one write port and two registered read ports
`timescale 1ns/1ns
`default_nettype none
module ljd_mem #(
   parameter int W = 32,
   parameter int AW = 10
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic [AW-1:0] raddr_a,
   output logic [W-1:0] rdata_a,
   input wire logic [AW-1:0] raddr_b,
   output logic [W-1:0] rdata_b
);
   // Storage array, no reset so it maps onto block memory
   logic [W-1:0] mem [0:(1<<AW)-1];

   // ------------------------------------------------------------
   // Write then read; reads see the old word on a same-edge write
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
   end
endmodule
`default_nettype wire

// ### verilog/ljd_bcd_dec.sv
// Four-digit BCD decrement with validity check
`timescale 1ns/1ns
`default_nettype none
module ljd_bcd_dec (
   input wire logic [15:0] val,
   output logic [15:0] dec,
   output logic is_bcd
);
   // ------------------------------------------------------------
   // Ripple borrow through the digits, lowest first
   // ------------------------------------------------------------
   always_comb begin
      logic borrow;
      logic [3:0] d;
      d = 4'h0;
      borrow = 1'b1;
      is_bcd = 1'b1;
      dec = val;
      for (int i = 0; i < 4; i++) begin
         d = val[4*i +: 4];
         // Digits above nine make the word unusable
         if (d > 4'h9) begin
            is_bcd = 1'b0;
         end
         if (borrow) begin
            if (d == 4'h0) begin
               dec[4*i +: 4] = 4'h9;
            end else begin
               dec[4*i +: 4] = d - 4'h1;
               borrow = 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### verilog/ljd_engine.sv
// Ladder engine: skip regions, idle words, end flags and tenth-second delay timers
`timescale 1ns/1ns
`default_nettype none
module ljd_engine #(
   parameter int TICK_CYCLES = ljd_pkg::TENTH_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [ljd_pkg::INSN_W-1:0] avs_writedata,
   output logic [ljd_pkg::INSN_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [ljd_pkg::IN_W-1:0] in_word_pin,
   output logic [ljd_pkg::IN_W-1:0] out_bits,
   output logic scan_done
);
   import ljd_pkg::*;

   // ------------------------------------------------------------
   // State record
   // ------------------------------------------------------------
   typedef struct packed {
      ljd_st_e st;                            // Sequencer state
      logic [PROG_AW-1:0] pc;                 // Program address
      logic cond;                             // Execution condition
      logic [FLAGS_W-1:0] flags;              // Condition flags
      logic [1:0] mode;                       // Operating mode
      logic clr_req;                          // Program clear pending
      logic [PROG_AW-1:0] paddr;              // Bus pointer into program
      logic [SLOT_AW-1:0] saddr;              // Bus pointer into slots
      logic [1:0] wc;                         // Bus wait count
      logic [INSN_W-1:0] rdata;               // Bus read data
      logic [31:0] work;                      // Work bits
      logic [31:0] hist;                      // Pulse history per work bit
      logic [PROG_AW-1:0] idx;                // Clear / init walker
      logic [23:0] tick_count;                // Tenth-second prescaler
      logic [7:0] now;                        // Tenth-second tick number
      logic [31:0] scans;                     // Completed scans
      logic scan_pulse;                       // End executed
      logic [SKIP_SLOTS-1:0][PROG_AW-1:0] dest_tab; // Destination addresses
      logic [SKIP_SLOTS-1:0] dest_ok;         // Destination known
      logic [IN_W-1:0] s1;                    // Input synchroniser
      logic [IN_W-1:0] s2;
      logic [IN_W-1:0] s3;
      logic [IN_W-1:0] inw;                   // Filtered input word
   } ljd_regs_s;

   ljd_regs_s r_reg, r_next;

   localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
   localparam logic [PROG_AW-1:0] PROG_LAST = '1;
   localparam logic [PROG_AW-1:0] SLOT_LAST = PROG_AW'(SLOTS - 1);

   // Memory ports
   logic pwe, swe;
   logic [PROG_AW-1:0] pwaddr;
   logic [INSN_W-1:0] pwdata, pd, pdb;
   logic [SLOT_AW-1:0] swaddr;
   logic [SLOT_W-1:0] swdata, sd, sdb;
   // Decoded fields of the word being executed
   logic [6:0] op;
   logic [SKIP_W-1:0] skip_num;
   logic [SLOT_AW-1:0] pd_slot;
   logic [CONST_W-1:0] preset, cur_dec;
   logic preset_ok, running;
   logic [INSN_W-1:0] rd;

   assign op = pd[INSN_W-1:OP_LSB];
   assign skip_num = pd[SKIP_W-1:0];
   assign pd_slot = pd[SLOT_LSB +: SLOT_AW];
   assign running = (r_reg.mode == MODE_RUN) || (r_reg.mode == MODE_MON);
   assign preset = (op == OP_DELAY_IN && running) ? r_reg.inw : pd[CONST_W-1:0];

   // Program memory, filled by software and the clear walker
   ljd_mem #(.W(INSN_W), .AW(PROG_AW)) u_prog (
      .clk(ref_clk),
      .we(pwe),
      .waddr(pwaddr),
      .wdata(pwdata),
      .raddr_a(r_reg.pc),
      .rdata_a(pd),
      .raddr_b(r_reg.paddr),
      .rdata_b(pdb)
   );

   ljd_mem #(.W(SLOT_W), .AW(SLOT_AW)) u_slot (
      .clk(ref_clk),
      .we(swe),
      .waddr(swaddr),
      .wdata(swdata),
      .raddr_a(pd_slot),
      .rdata_a(sd),
      .raddr_b(r_reg.saddr),
      .rdata_b(sdb)
   );

   // decimal borrow on the running value
   ljd_bcd_dec u_cur_dec (
      .val(sd[CONST_W-1:0]),
      .dec(cur_dec),
      .is_bcd()
   );

   // Preset digit check only
   ljd_bcd_dec u_preset_chk (
      .val(preset),
      .dec(),
      .is_bcd(preset_ok)
   );

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      r_next = r_reg;
      pwe = 1'b0;
      pwaddr = r_reg.paddr;
      pwdata = avs_writedata;
      swe = 1'b0;
      swaddr = pd_slot;
      swdata = sd;
      rd = '0;
      r_next.scan_pulse = 1'b0;

      // Three-stage input sync, a bit moves when stages two and three agree
      r_next.s1 = in_word_pin;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      r_next.inw = (r_reg.s2 & r_reg.s3) | (r_reg.inw & (r_reg.s2 ^ r_reg.s3));

      if (r_reg.tick_count == TICK_LAST) begin
         r_next.tick_count = '0;
         r_next.now = r_reg.now + 8'h01;
      end else begin
         r_next.tick_count = r_reg.tick_count + 24'h000001;
      end

      // Bus read mux, sampled while the memories are settled
      unique case (avs_address)
         REG_CTRL: begin
            rd[1:0] = r_reg.mode;
            rd[CTRL_CLEAR_BIT] = r_reg.clr_req;
         end
         REG_STATUS: begin
            rd[ST_RUN_BIT] = running;
            rd[ST_CLR_BIT] = r_reg.clr_req;
            rd[ST_PC_LSB +: PROG_AW] = r_reg.pc;
         end
         REG_FLAGS: rd[FLAGS_W-1:0] = r_reg.flags;
         REG_PADDR: rd[PROG_AW-1:0] = r_reg.paddr;
         REG_PDATA: rd = pdb;
         REG_SADDR: rd[SLOT_AW-1:0] = r_reg.saddr;
         REG_SDATA: begin
            rd[CONST_W-1:0] = sdb[CONST_W-1:0];
            rd[SD_DONE_BIT] = sdb[SW_DONE];
         end
         REG_BITS: rd = r_reg.work;
         REG_SCANS: rd = r_reg.scans;
         REG_INPUT: rd[IN_W-1:0] = r_reg.inw;
         default: rd = '0;
      endcase

      // Two wait cycles so pointer updates reach memory reads first
      if (avs_read || avs_write) begin
         r_next.wc = (r_reg.wc == BUS_LAST_WAIT) ? 2'h0 : r_reg.wc + 2'h1;
      end else begin
         r_next.wc = 2'h0;
      end
      if (avs_read && r_reg.wc == 2'h1) begin
         r_next.rdata = rd;
      end

      // Writes land on the edge where waitrequest is low
      if (avs_write && r_reg.wc == BUS_LAST_WAIT) begin
         unique case (avs_address)
            REG_CTRL: begin
               r_next.mode = avs_writedata[1:0];
               if (avs_writedata[CTRL_CLEAR_BIT]) begin
                  r_next.clr_req = 1'b1;
               end
            end
            REG_FLAGS: r_next.flags = avs_writedata[FLAGS_W-1:0];
            REG_PADDR: r_next.paddr = avs_writedata[PROG_AW-1:0];
            REG_SADDR: r_next.saddr = avs_writedata[SLOT_AW-1:0];
            REG_PDATA: begin
               // Words written during a clear are dropped
               if (r_reg.st != S_CLEAR) begin
                  pwe = 1'b1;
                  r_next.paddr = r_reg.paddr + 1'b1;
                  // remember where each numbered destination up to 99 sits
                  if (avs_writedata[INSN_W-1:OP_LSB] == OP_DEST &&
                      avs_writedata[SKIP_W-1:0] != SKIP_SHARED &&
                      avs_writedata[SKIP_W-1:0] <= SKIP_MAX) begin
                     r_next.dest_tab[avs_writedata[SKIP_W-1:0]] = r_reg.paddr;
                     r_next.dest_ok[avs_writedata[SKIP_W-1:0]] = 1'b1;
                  end
               end
            end
            default: begin
               // Read-only or unmapped, ignored
            end
         endcase
      end

      // Sequencer
      unique case (r_reg.st)
         // Power-up: every slot idle, value zero, completion off
         S_INIT: begin
            swe = 1'b1;
            swaddr = r_reg.idx[SLOT_AW-1:0];
            swdata = '0;
            r_next.idx = r_reg.idx + 1'b1;
            if (r_reg.idx == SLOT_LAST) begin
               r_next.idx = '0;
               r_next.st = S_IDLE;
            end
         end
         S_IDLE: begin
            if (r_reg.clr_req) begin
               r_next.idx = '0;
               r_next.st = S_CLEAR;
            end else if (running) begin
               r_next.st = S_FETCH;
            end
         end
         // clear fills memory with idle words
         S_CLEAR: begin
            pwe = 1'b1;
            pwaddr = r_reg.idx;
            pwdata = IDLE_WORD;
            r_next.dest_ok = '0;
            r_next.idx = r_reg.idx + 1'b1;
            if (r_reg.idx == PROG_LAST) begin
               // A clear written on this same edge is kept, the set wins
               r_next.clr_req = avs_write && r_reg.wc == BUS_LAST_WAIT &&
                  avs_address == REG_CTRL && avs_writedata[CTRL_CLEAR_BIT];
               r_next.pc = '0;
               r_next.st = S_IDLE;
            end
         end
         // One cycle for the program word to arrive
         S_FETCH: begin
            if (!running || r_reg.clr_req) begin
               r_next.pc = '0;
               r_next.st = S_IDLE;
            end else begin
               r_next.st = S_EXEC;
            end
         end
         S_EXEC: begin
            r_next.pc = r_reg.pc + 1'b1;
            r_next.st = S_FETCH;
            unique case (op)
               // end clears flags and restarts the scan
               OP_END: begin
                  r_next.flags = '0;
                  r_next.pc = '0;
                  r_next.scans = r_reg.scans + 32'h1;
                  r_next.scan_pulse = 1'b1;
               end
               OP_LD: begin
                  r_next.cond = pd[5] ? r_reg.inw[pd[3:0]] : r_reg.work[pd[4:0]];
               end
               OP_OUT: r_next.work[pd[4:0]] = r_reg.cond;
               // pulse bit only moves when executed
               OP_RISE: begin
                  r_next.work[pd[4:0]] = r_reg.cond & ~r_reg.hist[pd[4:0]];
                  r_next.hist[pd[4:0]] = r_reg.cond;
               end
               OP_FALL: begin
                  r_next.work[pd[4:0]] = ~r_reg.cond & r_reg.hist[pd[4:0]];
                  r_next.hist[pd[4:0]] = r_reg.cond;
               end
               OP_SKIP: begin
                  if (!r_reg.cond) begin
                     if (skip_num != SKIP_SHARED && r_next.dest_ok[skip_num]) begin
                        r_next.pc = r_reg.dest_tab[skip_num] + 1'b1;
                     end else begin
                        r_next.st = S_SRCH_F;
                     end
                  end
               end
               OP_LD_SLOT, OP_DELAY, OP_DELAY_IN, OP_CMP: begin
                  r_next.pc = r_reg.pc;
                  r_next.st = S_SLOT;
               end
               // idle words and unknown codes just advance
               default: begin
               end
            endcase
         end
         // Slot data for the current word is now valid
         S_SLOT: begin
            r_next.pc = r_reg.pc + 1'b1;
            r_next.st = S_FETCH;
            if (op == OP_LD_SLOT) begin
               r_next.cond = sd[SW_DONE];
            end else if (op == OP_CMP) begin
               // current value compared as a word
               r_next.flags[FLG_GT] = sd[CONST_W-1:0] > pd[CONST_W-1:0];
               r_next.flags[FLG_EQU] = sd[CONST_W-1:0] == pd[CONST_W-1:0];
               r_next.flags[FLG_LT] = sd[CONST_W-1:0] < pd[CONST_W-1:0];
            end else begin
               swe = 1'b1;
               // Bad digits still time, but flag the error
               if (!preset_ok) begin
                  r_next.flags[FLG_IERR] = 1'b1;
               end
               if (!r_reg.cond) begin
                  // reload preset while condition is OFF
                  swdata = {1'b0, 1'b0, r_reg.now, preset};
               end else if (!sd[SW_RUN]) begin
                  // First ON pass; a zero preset completes at once
                  swdata = {preset == '0, 1'b1, r_reg.now, preset};
               end else if (sd[SW_STAMP_LSB +: 8] != r_reg.now) begin
                  // one step per elapsed tenth, catching up across long scans
                  swdata[SW_STAMP_LSB +: 8] = sd[SW_STAMP_LSB +: 8] + 8'h01;
                  if (sd[CONST_W-1:0] != '0) begin
                     swdata[CONST_W-1:0] = cur_dec;
                     swdata[SW_DONE] = sd[SW_DONE] | (cur_dec == '0);
                  end
               end
            end
         end
         S_SRCH_F: r_next.st = S_SRCH_C;
         S_SRCH_C: begin
            if (op == OP_DEST && skip_num == SKIP_SHARED) begin
               r_next.pc = r_reg.pc + 1'b1;
               r_next.st = S_FETCH;
            end else if (op == OP_END || r_reg.pc == PROG_LAST) begin
               // no destination: land on the end word, or on the last program word
               r_next.st = S_FETCH;
            end else begin
               r_next.pc = r_reg.pc + 1'b1;
               r_next.st = S_SRCH_F;
            end
         end
      endcase

      // Synchronous reset
      if (!rst_n) begin
         r_next = '0;
         r_next.st = S_INIT;
         r_next.mode = MODE_RST;
         pwe = 1'b0;
         swe = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      r_reg <= r_next;
   end

   // Outputs
   assign avs_readdata = r_reg.rdata;
   assign avs_waitrequest = (avs_read | avs_write) & (r_reg.wc != BUS_LAST_WAIT);
   assign out_bits = r_reg.work[IN_W-1:0];
   assign scan_done = r_reg.scan_pulse;
endmodule
`default_nettype wire

// ### sim/ljd_engine_asserts.sv
// Port checker for the ladder engine bus and scan outputs
`timescale 1ns/1ns
`default_nettype none
module ljd_engine_asserts (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [ljd_pkg::INSN_W-1:0] avs_writedata,
   input wire logic [ljd_pkg::INSN_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [ljd_pkg::IN_W-1:0] in_word_pin,
   input wire logic [ljd_pkg::IN_W-1:0] out_bits,
   input wire logic scan_done
);
   import ljd_pkg::*;
   // --------------------------------------------
   // Mode as software last wrote it
   // --------------------------------------------
   logic [1:0] mode_reg;
   // Tracks completed control writes only
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mode_reg <= MODE_RST;
      end else if (avs_write && !avs_waitrequest && avs_address == REG_CTRL) begin
         mode_reg <= avs_writedata[1:0];
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_req; $rose(avs_read || avs_write); endsequence
   sequence s_two_wait; avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest; endsequence
   sequence s_rd(a); avs_read && !avs_waitrequest && avs_address == a; endsequence
   sequence s_steady; $stable(in_word_pin) [*8]; endsequence
   property p_wait_two; s_req |-> s_two_wait; endproperty
   property p_wait_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
   property p_rst_vals; $rose(rst_n) |-> avs_readdata == '0 && out_bits == '0 && !scan_done; endproperty
   property p_done_pulse; scan_done |=> !scan_done; endproperty
   property p_rd_hold; !avs_read |=> $stable(avs_readdata); endproperty
   property p_unmapped; s_rd(6'h3C) |-> avs_readdata == '0; endproperty
   property p_in_word; s_steady ##0 s_rd(REG_INPUT) |-> avs_readdata[IN_W-1:0] == in_word_pin; endproperty
   property p_quiet; (mode_reg == MODE_PROG) [*6] |-> !scan_done; endproperty
   a_wait_two: assert property (p_wait_two) else $error("wait count wrong");
   a_wait_idle: assert property (p_wait_idle) else $error("wait without request");
   a_rst_vals: assert property (p_rst_vals) else $error("outputs not clear after reset");
   a_done_pulse: assert property (p_done_pulse) else $error("scan pulse too long");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_in_word: assert property (p_in_word) else $error("input word wrong");
   a_quiet: assert property (p_quiet) else $error("scan while stopped");
endmodule
bind ljd_engine ljd_engine_asserts u_chk (.ref_clk, .rst_n, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .in_word_pin,
   .out_bits, .scan_done);
`default_nettype wire

// ### sim/ljd_engine_test.sv
// Self-checking bench for the ladder engine
`timescale 1ns/1ns
`default_nettype none
module ljd_engine_test;
   import ljd_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [15:0] in_word_pin = '0;
   logic [15:0] out_bits;
   logic scan_done;
   logic [31:0] rd;
   int errors = 0;
   int checks_done = 0;
   int cyc = 0;
   // Skip regions, shared skips, pulse, timer on slot 100, idle, end
   // numbered skips used once
   logic [31:0] prog [20] = '{32'h04000022, 32'h08000001, 32'h04000020, 32'h1A000005,
      32'h0C000001, 32'h0A000001, 32'h04000022, 32'h08000000, 32'h08000000, 32'h0C000002,
      32'h0A000000, 32'h0C000006, 32'h0A000000, 32'h0C000003, 32'h04000021, 32'h20640003,
      32'h06640000, 32'h0C000004, 32'h00000000, 32'h02000000};
   logic [15:0] row_in [6] = '{16'h5, 16'h0, 16'h4, 16'h2, 16'h0, 16'h6};
   logic [31:0] row_exp [6] = '{32'h4E, 32'h06, 32'h4C, 32'h14, 32'h04, 32'h5C};
   // Input-word preset on slot 101, compare, end
   logic [31:0] prog2 [4] = '{32'h04000021, 32'h22650000, 32'h28650007, 32'h02000000};
   ljd_engine #(.TICK_CYCLES(20)) uut (.ref_clk, .rst_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .in_word_pin,
      .out_bits, .scan_done);
   always #5 ref_clk = ~ref_clk;
   // Hang guard; run needs about 5100 cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors = errors + 1;
         finish_test();
      end
   end
   // --------------------------------------------
   // Bus, compare, input-hold and finish tasks
   // --------------------------------------------
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      // Held until the rising edge that samples waitrequest low
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic hold_in(input logic [15:0] v);
      @(posedge ref_clk);
      in_word_pin <= v;
      repeat (300) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      bus(1'b1, REG_CTRL, 32'h4);
      do bus(1'b0, REG_STATUS, 32'h0); while (rd[ST_CLR_BIT] !== 1'b0);
      bus(1'b1, REG_PADDR, 32'h5);
      bus(1'b0, REG_PDATA, 32'h0);
      chk(rd, IDLE_WORD);
      bus(1'b1, REG_PADDR, 32'h0);
      foreach (prog[i]) bus(1'b1, REG_PDATA, prog[i]);
      bus(1'b1, REG_FLAGS, 32'h1F);
      bus(1'b0, REG_FLAGS, 32'h0);
      chk(rd, 32'h1F);
      bus(1'b1, REG_CTRL, {30'h0, MODE_RUN});
      // Ordinary cases: input word against work bits
      foreach (row_in[i]) begin
         hold_in(row_in[i]);
         chk({16'h0, out_bits & 16'h005E}, row_exp[i]);
      end
      bus(1'b1, REG_SADDR, 32'd100);
      bus(1'b0, REG_SDATA, 32'h0);
      chk(rd & 32'h8000FFFF, 32'h80000000);
      hold_in(16'h0);
      bus(1'b0, REG_SDATA, 32'h0);
      chk(rd & 32'h8000FFFF, 32'h00000003);
      // Pulse set, then its region skipped
      hold_in(16'h4);
      @(posedge ref_clk);
      in_word_pin <= 16'h5;
      do @(negedge ref_clk); while (out_bits[5] !== 1'b1);
      hold_in(16'h1);
      chk({31'h0, out_bits[5]}, 32'h1);
      hold_in(16'h5);
      chk({31'h0, out_bits[5]}, 32'h0);
      bus(1'b1, 6'h3C, 32'hFFFFFFFF);
      bus(1'b0, 6'h3C, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, REG_FLAGS, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, REG_INPUT, 32'h0);
      chk({16'h0, rd[15:0]}, 32'h5);
      bus(1'b1, REG_CTRL, 32'h0);
      // Monitor mode takes the preset from the input word
      bus(1'b1, REG_PADDR, 32'h0);
      foreach (prog2[i]) bus(1'b1, REG_PDATA, prog2[i]);
      bus(1'b1, REG_CTRL, {30'h0, MODE_MON});
      hold_in(16'h5);
      bus(1'b1, REG_SADDR, 32'd101);
      bus(1'b0, REG_SDATA, 32'h0);
      chk(rd & 32'h8000FFFF, 32'h00000005);
      repeat (10) @(posedge ref_clk);
      // Reset again in mid-run: outputs and counters back to zero
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(negedge ref_clk);
      chk({16'h0, out_bits}, 32'h0);
      bus(1'b0, REG_SCANS, 32'h0);
      chk(rd, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
